// >>> mst_pkg.sv
package mst_pkg;

	// ------------------------------------------------------------
	// Counts and display values
	// ------------------------------------------------------------
	localparam int unsigned CNT_W        = 11;
	localparam logic [10:0] DIG_COUNT    = 11'h760;
	localparam logic [10:0] FULL_SCALE   = 11'h7cf;
	localparam logic [10:0] INTEG_COUNTS = 11'h3e8;
	localparam logic [10:0] PASS_MAIN_LO = 11'h3e3;
	localparam logic [10:0] PASS_MAIN_HI = 11'h3ed;
	localparam logic [10:0] PASS_DISS_HI = 11'h005;

	// ------------------------------------------------------------
	// Sequence shape
	// ------------------------------------------------------------
	localparam int unsigned NUM_RANGES    = 5;
	localparam int unsigned RANGE_W       = 3;
	localparam int unsigned DP_STEPS      = 3;
	localparam int unsigned SAMPLE_EDGES  = 8;
	localparam int unsigned ABSENT_CYCLES = 64;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ     = 250;
	localparam int unsigned NULL_NS     = 40;
	localparam int unsigned NULL_CYCLES = (NULL_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MST_NORMAL  = 2'h0,
		MST_DIGITAL = 2'h1,
		MST_ANALOG  = 2'h2
	} mst_mode_t;

	typedef enum logic [1:0] {
		MST_SERIES_INDUCTANCE_FN    = 2'h0,
		MST_PARALLEL_CAPACITANCE_FN = 2'h1,
		MST_SERIES_RESISTANCE_FN    = 2'h2
	} mst_fn_t;

	typedef enum logic [7:0] {
		MST_IDLE     = 8'h00,
		MST_WAIT     = 8'h01,
		MST_NULL     = 8'h02,
		MST_INTEG    = 8'h03,
		MST_DISCH    = 8'h04,
		MST_SHOW     = 8'h05,
		MST_INTERVAL = 8'h06
	} mst_state_t;

endpackage

// >>> mst_tmr_if.sv
`timescale 1ns/1ps
interface mst_tmr_if;
	logic start;
	logic done;

	modport seq (output start, input done);
	modport tmr (input start, output done);
endinterface

// >>> mst_interval_timer.sv
`timescale 1ns/1ps
module mst_interval_timer #(
	parameter int unsigned SAMPLE_EDGES  = mst_pkg::SAMPLE_EDGES,
	parameter int unsigned ABSENT_CYCLES = mst_pkg::ABSENT_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Reference sample clock, taken as synchronous
	input  wire logic quad_ref_sample_clock_i,
	// Sequencer side
	mst_tmr_if.tmr    tif
);
	initial begin
		if (SAMPLE_EDGES < 1 || SAMPLE_EDGES > 255 || ABSENT_CYCLES < 1 || ABSENT_CYCLES > 65535) begin
			$error("mst_interval_timer: parameter out of range");
		end
	end

	logic        busy_reg, busy_next;
	logic        done_reg, done_next;
	logic        prev_reg, prev_next;
	logic [7:0]  edge_reg, edge_next;
	logic [15:0] idle_reg, idle_next;

	// ------------------------------------------------------------
	// Interval count: reference edges, or an idle timeout if edges stop
	// ------------------------------------------------------------
	always_comb begin
		busy_next = busy_reg;
		done_next = 1'b0;
		prev_next = quad_ref_sample_clock_i;
		edge_next = edge_reg;
		idle_next = idle_reg;
		if (tif.start) begin
			busy_next = 1'b1;
			edge_next = 8'h00;
			idle_next = 16'h0000;
		end else if (busy_reg) begin
			if (quad_ref_sample_clock_i && !prev_reg) begin
				edge_next = edge_reg + 8'h01;
				idle_next = 16'h0000;
				if (edge_reg == 8'(SAMPLE_EDGES - 1)) begin
					busy_next = 1'b0;
					done_next = 1'b1;
				end
			end else begin
				idle_next = idle_reg + 16'h0001;
				if (idle_reg == 16'(ABSENT_CYCLES - 1)) begin
					busy_next = 1'b0; // Missing reference still ends the wait
					done_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			prev_reg <= 1'b0;
			edge_reg <= 8'h00;
			idle_reg <= 16'h0000;
		end else begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			prev_reg <= prev_next;
			edge_reg <= edge_next;
			idle_reg <= idle_next;
		end
	end

	assign tif.done = done_reg;
endmodule

// >>> mst_self_test_seq.sv
`timescale 1ns/1ps
module mst_self_test_seq #(
	parameter int unsigned NUM_RANGES    = mst_pkg::NUM_RANGES,
	parameter int unsigned SAMPLE_EDGES  = mst_pkg::SAMPLE_EDGES,
	parameter int unsigned ABSENT_CYCLES = mst_pkg::ABSENT_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Front panel
	input  wire logic [1:0]  test_sel_i,
	input  wire logic        external_trigger_mode_i,
	input  wire logic        manual_trigger_i,
	// Analog section status
	input  wire logic        integrator_saturated_i,
	input  wire logic        quad_ref_sample_clock_i,
	input  wire logic        zero_cross_i,
	// Analog section controls
	output logic [2:0]       range_sel_o,
	output logic [1:0]       function_sel_o,
	output logic             phase_quad_o,
	output logic             integrate_o,
	output logic             discharge_o,
	output logic             offset_null_ctl_o,
	// Displays
	output logic [10:0]      main_count_o,
	output logic             main_neg_o,
	output logic             main_blank_o,
	output logic [10:0]      diss_count_o,
	output logic             diss_blank_o,
	output logic [1:0]       decimal_pos_o,
	output logic             out_of_range_o,
	output logic             pass_o,
	output logic             fault_o,
	// Trace
	output logic [7:0]       state_code_o
);
	initial begin
		if (NUM_RANGES < 1 || NUM_RANGES > 7) begin
			$error("mst_self_test_seq: NUM_RANGES out of range");
		end
	end

	localparam logic [2:0] LAST_RANGE = 3'(NUM_RANGES);

	mst_tmr_if tif ();

	mst_interval_timer #(
		.SAMPLE_EDGES  (SAMPLE_EDGES),
		.ABSENT_CYCLES (ABSENT_CYCLES)
	) u_timer (
		.clk_i                   (clk_i),
		.rst_b_i                 (rst_b_i),
		.quad_ref_sample_clock_i (quad_ref_sample_clock_i),
		.tif                     (tif.tmr)
	);

	mst_pkg::mst_state_t state_reg, state_next;
	mst_pkg::mst_mode_t  mode_reg, mode_next;
	logic [2:0]  range_reg, range_next;
	logic [1:0]  fn_reg, fn_next;
	logic        rd_reg, rd_next;
	logic [10:0] cnt_reg, cnt_next;
	logic [10:0] mres_reg, mres_next;
	logic [10:0] dres_reg, dres_next;
	logic        never_reg, never_next;
	logic        immed_reg, immed_next;
	logic        sat_reg, sat_next;
	logic        wrap_reg, wrap_next;
	logic        tstart_reg, tstart_next;
	logic [10:0] mcnt_next, dcnt_next;
	logic        mneg_next, mblank_next, dblank_next, pass_next, fault_next;
	logic [1:0]  dp_next;
	logic        over;

	assign over = (range_reg == LAST_RANGE);
	assign tif.start = tstart_reg;

	// ------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------
	always_comb begin
		state_next  = state_reg;
		mode_next   = mode_reg;
		range_next  = range_reg;
		fn_next     = fn_reg;
		rd_next     = rd_reg;
		cnt_next    = cnt_reg;
		mres_next   = mres_reg;
		dres_next   = dres_reg;
		never_next  = never_reg;
		immed_next  = immed_reg;
		sat_next    = sat_reg;
		wrap_next   = wrap_reg;
		tstart_next = 1'b0;
		mcnt_next   = main_count_o;
		mneg_next   = main_neg_o;
		mblank_next = main_blank_o;
		dcnt_next   = diss_count_o;
		dblank_next = diss_blank_o;
		dp_next     = decimal_pos_o;
		pass_next   = pass_o;
		fault_next  = fault_o;
		unique case (state_reg)
			mst_pkg::MST_IDLE: begin
				range_next = 3'h0;
				fn_next    = 2'h0;
				rd_next    = 1'b0;
				wrap_next  = 1'b0;
				if (test_sel_i == mst_pkg::MST_DIGITAL || test_sel_i == mst_pkg::MST_ANALOG) begin
					mode_next  = mst_pkg::mst_mode_t'(test_sel_i);
					state_next = mst_pkg::MST_WAIT;
				end else begin
					mode_next = mst_pkg::MST_NORMAL;
				end
			end
			mst_pkg::MST_WAIT: begin
				if (!external_trigger_mode_i || manual_trigger_i) begin
					cnt_next = 11'h000;
					rd_next  = 1'b0;
					sat_next = 1'b0;
					state_next = (mode_reg == mst_pkg::MST_DIGITAL) ? mst_pkg::MST_SHOW
						: mst_pkg::MST_NULL;
				end
			end
			mst_pkg::MST_NULL: begin
				cnt_next = cnt_reg + 11'h001;
				if (cnt_reg == 11'(mst_pkg::NULL_CYCLES - 1)) begin
					cnt_next   = 11'h000;
					state_next = mst_pkg::MST_INTEG;
				end
			end
			mst_pkg::MST_INTEG: begin
				cnt_next = cnt_reg + 11'h001;
				if (integrator_saturated_i) begin
					sat_next = 1'b1;
				end
				if (cnt_reg == mst_pkg::INTEG_COUNTS - 11'h001) begin
					cnt_next   = 11'h000;
					state_next = mst_pkg::MST_DISCH;
				end
			end
			mst_pkg::MST_DISCH: begin
				cnt_next = cnt_reg + 11'h001;
				if (zero_cross_i || cnt_reg == mst_pkg::FULL_SCALE) begin
					cnt_next = 11'h000;
					if (!rd_reg) begin
						mres_next  = cnt_reg;
						never_next = !zero_cross_i;
						immed_next = zero_cross_i && (cnt_reg == 11'h000);
						rd_next    = 1'b1;
						state_next = mst_pkg::MST_NULL;
					end else begin
						dres_next  = zero_cross_i ? cnt_reg : mst_pkg::FULL_SCALE;
						state_next = mst_pkg::MST_SHOW;
					end
				end
			end
			mst_pkg::MST_SHOW: begin
				dp_next     = 2'(range_reg % 3'(mst_pkg::DP_STEPS));
				mneg_next   = 1'b0;
				mblank_next = over;
				dblank_next = over;
				pass_next   = 1'b0;
				fault_next  = 1'b0;
				if (mode_reg == mst_pkg::MST_DIGITAL) begin
					mcnt_next  = mst_pkg::DIG_COUNT;
					dcnt_next  = mst_pkg::DIG_COUNT;
					range_next = over ? 3'h0 : range_reg + 3'h1;
					wrap_next  = over;
				end else begin
					mcnt_next   = mres_reg;
					dcnt_next   = dres_reg;
					mblank_next = 1'b0;
					dblank_next = 1'b0;
					if (over && (never_reg || immed_reg)) begin
						mblank_next = 1'b1;
						dblank_next = 1'b1;
					end else if (never_reg) begin
						mcnt_next = mst_pkg::FULL_SCALE;
					end else if (immed_reg && sat_reg) begin
						mcnt_next = mst_pkg::FULL_SCALE;
						dcnt_next = mst_pkg::FULL_SCALE;
					end else if (immed_reg) begin
						mcnt_next   = 11'h000;
						mneg_next   = 1'b1;
						dblank_next = 1'b1;
					end
					pass_next = !over && !never_reg && !immed_reg
						&& mres_reg >= mst_pkg::PASS_MAIN_LO
						&& mres_reg <= mst_pkg::PASS_MAIN_HI
						&& dres_reg <= mst_pkg::PASS_DISS_HI;
					fault_next = !over && !pass_next;
					if (fn_reg == 2'(mst_pkg::MST_SERIES_RESISTANCE_FN)) begin
						fn_next    = 2'h0;
						range_next = over ? 3'h0 : range_reg + 3'h1;
						wrap_next  = over;
					end else begin
						fn_next = fn_reg + 2'h1;
					end
				end
				tstart_next = 1'b1;
				state_next  = mst_pkg::MST_INTERVAL;
			end
			mst_pkg::MST_INTERVAL: begin
				if (tif.done) begin
					state_next = wrap_reg ? mst_pkg::MST_IDLE : mst_pkg::MST_WAIT;
				end
			end
			default: begin
				state_next = mst_pkg::MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg         <= mst_pkg::MST_IDLE;
			mode_reg          <= mst_pkg::MST_NORMAL;
			range_reg         <= 3'h0;
			fn_reg            <= 2'h0;
			rd_reg            <= 1'b0;
			cnt_reg           <= 11'h000;
			mres_reg          <= 11'h000;
			dres_reg          <= 11'h000;
			never_reg         <= 1'b0;
			immed_reg         <= 1'b0;
			sat_reg           <= 1'b0;
			wrap_reg          <= 1'b0;
			tstart_reg        <= 1'b0;
			main_count_o      <= 11'h000;
			main_neg_o        <= 1'b0;
			main_blank_o      <= 1'b1;
			diss_count_o      <= 11'h000;
			diss_blank_o      <= 1'b1;
			decimal_pos_o     <= 2'h0;
			pass_o            <= 1'b0;
			fault_o           <= 1'b0;
			range_sel_o       <= 3'h0;
			function_sel_o    <= 2'h0;
			phase_quad_o      <= 1'b0;
			integrate_o       <= 1'b0;
			discharge_o       <= 1'b0;
			offset_null_ctl_o <= 1'b0;
			out_of_range_o    <= 1'b0;
			state_code_o      <= 8'h00;
		end else begin
			state_reg         <= state_next;
			mode_reg          <= mode_next;
			range_reg         <= range_next;
			fn_reg            <= fn_next;
			rd_reg            <= rd_next;
			cnt_reg           <= cnt_next;
			mres_reg          <= mres_next;
			dres_reg          <= dres_next;
			never_reg         <= never_next;
			immed_reg         <= immed_next;
			sat_reg           <= sat_next;
			wrap_reg          <= wrap_next;
			tstart_reg        <= tstart_next;
			main_count_o      <= mcnt_next;
			main_neg_o        <= mneg_next;
			main_blank_o      <= mblank_next;
			diss_count_o      <= dcnt_next;
			diss_blank_o      <= dblank_next;
			decimal_pos_o     <= dp_next;
			pass_o            <= pass_next;
			fault_o           <= fault_next;
			range_sel_o       <= range_next;
			function_sel_o    <= fn_next;
			phase_quad_o      <= rd_next;
			integrate_o       <= (state_next == mst_pkg::MST_INTEG);
			discharge_o       <= (state_next == mst_pkg::MST_DISCH);
			offset_null_ctl_o <= (state_next == mst_pkg::MST_NULL);
			out_of_range_o    <= (range_next == LAST_RANGE);
			state_code_o      <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [10:0] integ_len_reg;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			integ_len_reg <= 11'h000;
		end else begin
			integ_len_reg <= integrate_o ? integ_len_reg + 11'h001 : 11'h000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	dig_count_a: assert property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_DIGITAL && !over |=> main_count_o == 11'h760 && !main_blank_o) else $error("digital count wrong");
	range_step_a: assert property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_DIGITAL && !over |=> range_sel_o == $past(range_reg) + 3'h1) else $error("range did not step");
	ext_hold_a: assert property (state_reg == mst_pkg::MST_WAIT && external_trigger_mode_i && !manual_trigger_i |=> state_reg == mst_pkg::MST_WAIT) else $error("step without press");
	int_run_a: assert property (state_reg == mst_pkg::MST_WAIT && !external_trigger_mode_i |=> state_reg != mst_pkg::MST_WAIT) else $error("internal trigger stalled");
	interval_end_a: assert property (state_reg == mst_pkg::MST_INTERVAL |-> ##[0:600] state_reg != mst_pkg::MST_INTERVAL) else $error("interval never ended");
	integ_len_a: assert property ($fell(integrate_o) |-> $past(integ_len_reg) == 11'h3e7) else $error("integration length wrong");
	phase_sel_a: assert property ($rose(offset_null_ctl_o) |-> phase_quad_o == ($past(state_reg) == mst_pkg::MST_DISCH)) else $error("phase select wrong");
	fn_cycle_a: assert property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_ANALOG && fn_reg != 2'h2 |=> range_sel_o == $past(range_reg)) else $error("range moved mid pass");
	pass_win_a: assert property (pass_o |-> main_count_o >= 11'h3e3 && main_count_o <= 11'h3ed && diss_count_o <= 11'h005) else $error("pass outside window");
	full_scale_a: assert property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_ANALOG && never_reg && !over |=> main_count_o == 11'h7cf) else $error("full scale missing");
	stuck_blank_a: assert property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_ANALOG && over && (never_reg || immed_reg) |=> main_blank_o && diss_blank_o) else $error("abnormal range not blanked");
	neg_blank_a: assert property (main_neg_o |-> diss_blank_o && main_count_o == 11'h000) else $error("dissipation not blanked");
	mode_hold_a: assert property (state_reg != mst_pkg::MST_IDLE |=> $stable(mode_reg)) else $error("mode changed mid sequence");
	code_trace_a: assert property ((state_code_o == 8'h02) == offset_null_ctl_o && (state_code_o == 8'h03) == integrate_o && (state_code_o == 8'h04) == discharge_o) else $error("state code not traced");

	dig_show_c: cover property (state_reg == mst_pkg::MST_SHOW && mode_reg == mst_pkg::MST_DIGITAL);
	ana_pass_c: cover property (pass_o);
	ext_press_c: cover property (state_reg == mst_pkg::MST_WAIT && external_trigger_mode_i && manual_trigger_i);
	neg_show_c: cover property (main_neg_o);
endmodule

// >>> mst_analog_model.sv
`timescale 1ns/1ps
module mst_analog_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Controls from the sequencer
	input  wire logic       integrate_i,
	input  wire logic       discharge_i,
	input  wire logic       phase_quad_i,
	// Scenario knobs: stuck 1 = zero low, 2 = zero high
	input  wire logic [1:0] stuck_i,
	input  wire logic       sat_i,
	input  wire logic       ref_on_i,
	// Status back to the sequencer
	output logic            integrator_saturated_o,
	output logic            quad_ref_sample_clock_o,
	output logic            zero_cross_o
);
	logic [10:0] dcnt;
	logic [1:0]  qdiv;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dcnt <= 11'h000;
			qdiv <= 2'h0;
		end else begin
			dcnt <= discharge_i ? dcnt + 11'h001 : 11'h000;
			qdiv <= ref_on_i ? qdiv + 2'h1 : qdiv;
		end
	end

	// Crossing near 1000 counts in phase, almost at once at 90 degrees
	always_comb begin
		integrator_saturated_o  = sat_i & integrate_i;
		quad_ref_sample_clock_o = qdiv[1];
		zero_cross_o            = (stuck_i == 2'h2) ? 1'h1 :
			(stuck_i == 2'h1) ? 1'h0 :
			discharge_i & (dcnt >= (phase_quad_i ? 11'h002 : 11'h3e7));
	end
endmodule

// >>> meter_self_test_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
	$display("BAD %0t line %0d mismatch", $time, `__LINE__); end end
module meter_self_test_sequencer_bench;
	typedef struct packed {
		logic [1:0]  sel;
		logic [1:0]  stk;
		logic        integrator_saturated;
		logic        ref_on;
		logic [1:0]  kind;
		logic [10:0] main;
		logic        neg;
		logic        mb;
		logic        db;
		logic [1:0]  fn;
		logic [2:0]  rng;
		logic [2:0]  nxt;
	} mst_row_t;

	localparam int NR    = 2;
	localparam int NROWS = 10;

	logic        clk_i;
	logic        rst_b_i;
	logic [1:0]  test_sel_i;
	logic        external_trigger_mode_i;
	logic        manual_trigger_i;
	logic        integrator_saturated_i;
	logic        quad_ref_sample_clock_i;
	logic        zero_cross_i;
	logic [2:0]  range_sel_o;
	logic [1:0]  function_sel_o;
	logic        phase_quad_o;
	logic        integrate_o;
	logic        discharge_o;
	logic        offset_null_ctl_o;
	logic [10:0] main_count_o;
	logic        main_neg_o;
	logic        main_blank_o;
	logic [10:0] diss_count_o;
	logic        diss_blank_o;
	logic [1:0]  decimal_pos_o;
	logic        out_of_range_o;
	logic        pass_o;
	logic        fault_o;
	logic [7:0]  state_code_o;
	logic [1:0]  stuck;
	logic        integrator_saturated;
	logic        ref_on;
	logic        prev_int;
	logic [1:0]  fn_seen;
	logic        prev_null;
	mst_row_t    r;
	int          fails = 0;
	int          checks = 0;
	int          nint = 0;
	int          ilen = 0;
	int          nlen = 0;
	int          len;

	// Digital steps, then analog: three passes on range 0, stuck zero on range 1, overrange
	mst_row_t rows [NROWS] = '{
		'{2'h1, 2'h0, 1'h0, 1'h1, 2'h0, mst_pkg::DIG_COUNT, 1'h0, 1'h0, 1'h0, 2'h3, 3'h0, 3'h1},
		'{2'h2, 2'h0, 1'h0, 1'h0, 2'h0, mst_pkg::DIG_COUNT, 1'h0, 1'h0, 1'h0, 2'h3, 3'h1, 3'h2},
		'{2'h2, 2'h0, 1'h0, 1'h1, 2'h2, 11'h000, 1'h0, 1'h1, 1'h1, 2'h3, 3'h2, 3'h0},
		'{2'h2, 2'h0, 1'h0, 1'h1, 2'h1, 11'h000, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0, 3'h0},
		'{2'h2, 2'h0, 1'h0, 1'h1, 2'h1, 11'h000, 1'h0, 1'h0, 1'h0, 2'h1, 3'h0, 3'h0},
		'{2'h2, 2'h0, 1'h0, 1'h1, 2'h1, 11'h000, 1'h0, 1'h0, 1'h0, 2'h2, 3'h0, 3'h1},
		'{2'h2, 2'h1, 1'h0, 1'h1, 2'h0, mst_pkg::FULL_SCALE, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1, 3'h1},
		'{2'h2, 2'h2, 1'h0, 1'h1, 2'h0, 11'h000, 1'h1, 1'h0, 1'h1, 2'h1, 3'h1, 3'h1},
		'{2'h2, 2'h2, 1'h1, 1'h1, 2'h0, mst_pkg::FULL_SCALE, 1'h0, 1'h0, 1'h0, 2'h2, 3'h1, 3'h2},
		'{2'h2, 2'h1, 1'h0, 1'h1, 2'h2, 11'h000, 1'h0, 1'h1, 1'h1, 2'h3, 3'h2, 3'h2}
	};

	mst_self_test_seq #(.NUM_RANGES(NR)) dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .test_sel_i(test_sel_i),
		.external_trigger_mode_i(external_trigger_mode_i), .manual_trigger_i(manual_trigger_i),
		.integrator_saturated_i(integrator_saturated_i),
		.quad_ref_sample_clock_i(quad_ref_sample_clock_i), .zero_cross_i(zero_cross_i),
		.range_sel_o(range_sel_o), .function_sel_o(function_sel_o), .phase_quad_o(phase_quad_o),
		.integrate_o(integrate_o), .discharge_o(discharge_o),
		.offset_null_ctl_o(offset_null_ctl_o), .main_count_o(main_count_o),
		.main_neg_o(main_neg_o), .main_blank_o(main_blank_o), .diss_count_o(diss_count_o),
		.diss_blank_o(diss_blank_o), .decimal_pos_o(decimal_pos_o),
		.out_of_range_o(out_of_range_o), .pass_o(pass_o), .fault_o(fault_o),
		.state_code_o(state_code_o)
	);

	mst_analog_model partner (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .integrate_i(integrate_o), .discharge_i(discharge_o),
		.phase_quad_i(phase_quad_o), .stuck_i(stuck), .sat_i(integrator_saturated), .ref_on_i(ref_on),
		.integrator_saturated_o(integrator_saturated_i),
		.quad_ref_sample_clock_o(quad_ref_sample_clock_i), .zero_cross_o(zero_cross_i)
	);

	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	task give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wait_state(input mst_pkg::mst_state_t st, input int bound);
		int n;
		n = 0;
		@(negedge clk_i);
		while (state_code_o !== st && n < bound) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(state_code_o, st)
		if (state_code_o !== st)
			give_verdict();
	endtask

	// One step under external trigger: WAIT must hold until the button
	task trig();
		wait_state(mst_pkg::MST_WAIT, 300);
		repeat (10) @(negedge clk_i);
		`CHK(state_code_o, mst_pkg::MST_WAIT)
		nint = 0;
		@(posedge clk_i);
		manual_trigger_i <= 1'h1;
		@(posedge clk_i);
		manual_trigger_i <= 1'h0;
	endtask

	// Integration length, phase order and function of every reading
	always @(negedge clk_i) begin
		if (integrate_o === 1'h1)
			ilen++;
		if (integrate_o === 1'h1 && prev_int !== 1'h1) begin
			`CHK(phase_quad_o, nint[0])
			fn_seen = function_sel_o;
			nint++;
		end
		if (integrate_o !== 1'h1 && prev_int === 1'h1) begin
			`CHK(ilen, int'(mst_pkg::INTEG_COUNTS))
			`CHK(discharge_o, 1'h1)
			ilen = 0;
		end
		prev_int = integrate_o;
		if (offset_null_ctl_o === 1'h1)
			nlen++;
		if (offset_null_ctl_o !== 1'h1 && prev_null === 1'h1 && rst_b_i === 1'h1) begin
			`CHK(nlen, int'(mst_pkg::NULL_CYCLES))
			nlen = 0;
		end
		prev_null = offset_null_ctl_o;
	end

	initial begin
		rst_b_i = 1'h0;
		test_sel_i = 2'h0;
		external_trigger_mode_i = 1'h1;
		manual_trigger_i = 1'h0;
		stuck = 2'h0;
		integrator_saturated = 1'h0;
		ref_on = 1'h1;
		repeat (6) @(posedge clk_i);
		`CHK({main_blank_o, diss_blank_o, state_code_o}, {2'h3, 8'h00})
		rst_b_i <= 1'h1;
		test_sel_i <= 2'h3;
		repeat (20) @(negedge clk_i);
		`CHK(state_code_o, mst_pkg::MST_IDLE)
		$display("reset test done");
		for (int i = 0; i < NROWS; i++) begin
			r = rows[i];
			@(posedge clk_i);
			test_sel_i <= r.sel;
			stuck <= r.stk;
			integrator_saturated <= r.integrator_saturated;
			ref_on <= r.ref_on;
			trig();
			wait_state(mst_pkg::MST_INTERVAL, 20000);
			if (r.kind == 2'h0)
				`CHK(main_count_o, r.main)
			if (r.kind == 2'h0 && !r.db)
				`CHK(diss_count_o, r.main)
			if (r.kind == 2'h1) begin
				`CHK(main_count_o >= mst_pkg::PASS_MAIN_LO, 1'h1)
				`CHK(main_count_o <= mst_pkg::PASS_MAIN_HI, 1'h1)
				`CHK(diss_count_o <= mst_pkg::PASS_DISS_HI, 1'h1)
				`CHK({pass_o, fault_o}, 2'h2)
			end
			`CHK(main_neg_o, r.neg)
			`CHK(main_blank_o, r.mb)
			`CHK(diss_blank_o, r.db)
			if (r.fn != 2'h3)
				`CHK(fn_seen, r.fn)
			if (r.kind == 2'h0 && r.stk != 2'h0)
				`CHK({pass_o, fault_o}, 2'h1)
			`CHK(decimal_pos_o, 2'(r.rng % mst_pkg::DP_STEPS))
			`CHK(range_sel_o, r.nxt)
			`CHK(out_of_range_o, r.nxt == 3'(NR))
			len = 0;
			while (state_code_o === mst_pkg::MST_INTERVAL && len < 200) begin
				@(negedge clk_i);
				len++;
			end
			`CHK(len < 200, 1'h1)
			if (len >= 200)
				give_verdict();
			if (i < 3)
				`CHK(len < mst_pkg::ABSENT_CYCLES * 3 / 4, r.ref_on)
			$display("step %0d done", i);
		end
		@(posedge clk_i);
		external_trigger_mode_i <= 1'h0;
		stuck <= 2'h0;
		nint = 0;
		wait_state(mst_pkg::MST_INTERVAL, 20000);
		wait_state(mst_pkg::MST_NULL, 300);
		$display("internal trigger test done");
		@(posedge clk_i);
		rst_b_i <= 1'h0;
		@(negedge clk_i);
		`CHK({main_blank_o, diss_blank_o, state_code_o}, {2'h3, 8'h00})
		$display("second reset test done");
		give_verdict();
	end
endmodule
